// *** rtl/rbx_pkg.sv ***
// Constants for the relative jump and file bit set executer.
// Assumes a core clock split into four one-clock phases per instruction cycle.
package rbx_pkg;

  // ********************
  // Phases
  // ********************
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;
  localparam int NUM_PHASES = 4;

  // ********************
  // Opcodes
  // ********************
  localparam logic [7:0] OP_CARRY_CLEAR = 8'hE3;
  localparam logic [7:0] OP_NOT_NEGATIVE = 8'hE7;
  localparam logic [7:0] OP_NO_OVERFLOW = 8'hE5;
  localparam logic [7:0] OP_NONZERO = 8'hE1;
  localparam logic [7:0] OP_NEGATIVE = 8'hE6;
  localparam logic [4:0] OP_REL_JUMP = 5'h1A;
  localparam logic [3:0] OP_SET_BIT = 4'h8;

  // ********************
  // Fields
  // ********************
  localparam int BIT_LSB = 9;
  localparam int BIT_MSB = 11;
  localparam int ACCESS_FLAG = 8;
  localparam int SHORT_OFS_W = 8;
  localparam int LONG_OFS_W = 11;

  // ********************
  // Access bank split
  // ********************
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;

  // ********************
  // Defaults
  // ********************
  localparam int PC_WIDTH = 21;
  localparam logic [15:0] OPCODE_RESET = 16'h0000;

  typedef enum logic [0:0] {
    ST_EXEC = 1'b0,
    ST_FLUSH = 1'b1
  } rbx_state_e;

endpackage : rbx_pkg

// *** rtl/rbx_phase_gen.sv ***
// Four-phase sequencer for the instruction cycle.
// Assumes one clock; each phase lasts one clock.
`timescale 1ns/1ps
module rbx_phase_gen #(
  parameter int PHASES = rbx_pkg::NUM_PHASES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Phase out
  output logic [1:0] phase
);

  logic [1:0] next_phase;

  if (PHASES != rbx_pkg::NUM_PHASES) begin : g_phase_check
    $error("rbx_phase_gen serves exactly four phases");
  end

  always_comb begin
    next_phase = phase + 2'h1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase <= rbx_pkg::PH_Q1;
    end else begin
      phase <= next_phase;
    end
  end

endmodule : rbx_phase_gen

// *** rtl/rbx_exec.sv ***
// Decode and execute of flag-clear/flag-set relative jumps, the long relative jump and file bit set.
// Assumes opcode and incremented counter are valid in Q1 and file read data in Q2.
//
// How it works
// - High byte E3 jumps only while carry is 0.
// - High byte E7 jumps only while negative is 0.
// - High byte E5 jumps only while overflow is 0.
// - High byte E1 jumps only while zero is 0.
// - The low byte is a signed offset and a taken jump loads the incremented counter plus twice it.
// - A conditional jump is one word, one cycle if not taken and two if taken.
// - Q1 decodes, Q2 reads the offset, Q3 processes, Q4 writes the counter if taken; a second cycle is idle.
// - Pattern 11010 with an 11-bit signed offset is the unconditional relative jump.
// - The unconditional jump always loads counter plus twice offset and takes two cycles.
// - Pattern 1000 bbba ffffffff sets bit b of file register f in one cycle.
// - Access flag 0 uses the access bank, flag 1 uses the bank select value.
// - Bit set reads in Q2, modifies in Q3, writes in Q4 and leaves flags alone.
// - High byte E6 jumps only while negative is 1, with the same timing.
`timescale 1ns/1ps
module rbx_exec #(
  parameter int PC_W = rbx_pkg::PC_WIDTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Instruction in
  input wire logic [15:0] opcode,
  input wire logic [PC_W-1:0] pc_inc,
  // Status flags
  input wire logic status_carry,
  input wire logic status_zero,
  input wire logic status_overflow,
  input wire logic status_negative,
  // Bank and file data
  input wire logic [3:0] bank_select_value,
  input wire logic [7:0] file_rdata,
  // Phase and cycle
  output logic [1:0] phase,
  output logic nop_cycle,
  output logic decoded,
  // Counter write
  output logic pc_load,
  output logic [PC_W-1:0] pc_value,
  // File access
  output logic file_rd,
  output logic file_wr,
  output logic [11:0] file_addr,
  output logic [7:0] file_wdata
);

  if (PC_W < rbx_pkg::LONG_OFS_W + 2) begin : g_pc_w_check
    $error("rbx_exec needs a wider counter");
  end

  // ********************
  // Phase sequencer
  // ********************
  logic [1:0] ph;

  rbx_phase_gen #(
    .PHASES(rbx_pkg::NUM_PHASES)
  ) u_phase (
    .clk(clk),
    .reset(reset),
    .phase(ph)
  );

  // ********************
  // Decode helpers
  // ********************
  rbx_pkg::rbx_state_e state, next_state;
  logic [15:0] instr, next_instr;
  logic valid, next_valid;
  logic [PC_W-1:0] pc_base, next_pc_base, next_pc_value;
  logic taken, next_taken;
  logic next_pc_load, next_file_rd, next_file_wr, next_nop_cycle, next_decoded;
  logic [11:0] next_file_addr;
  logic [7:0] next_file_wdata, bit_mask;
  logic [1:0] next_phase_out;
  logic is_cond, is_long, is_set, cond_true, in_set, in_ours;
  logic [PC_W-1:0] short_ofs, long_ofs;
  logic [3:0] bank;

  always_comb begin
    is_cond = (instr[15:8] == rbx_pkg::OP_CARRY_CLEAR) || (instr[15:8] == rbx_pkg::OP_NOT_NEGATIVE) ||
              (instr[15:8] == rbx_pkg::OP_NO_OVERFLOW) || (instr[15:8] == rbx_pkg::OP_NONZERO) ||
              (instr[15:8] == rbx_pkg::OP_NEGATIVE);
    is_long = instr[15:11] == rbx_pkg::OP_REL_JUMP;
    is_set = instr[15:12] == rbx_pkg::OP_SET_BIT;
    in_set = opcode[15:12] == rbx_pkg::OP_SET_BIT;
    in_ours = in_set || (opcode[15:11] == rbx_pkg::OP_REL_JUMP) || (opcode[15:12] == 4'hE);
    case (instr[15:8])
      rbx_pkg::OP_CARRY_CLEAR: cond_true = !status_carry;
      rbx_pkg::OP_NOT_NEGATIVE: cond_true = !status_negative;
      rbx_pkg::OP_NO_OVERFLOW: cond_true = !status_overflow;
      rbx_pkg::OP_NONZERO: cond_true = !status_zero;
      rbx_pkg::OP_NEGATIVE: cond_true = status_negative;
      default: cond_true = 1'b0;
    endcase
    short_ofs = {{(PC_W-rbx_pkg::SHORT_OFS_W-1){instr[7]}}, instr[7:0], 1'b0};
    long_ofs = {{(PC_W-rbx_pkg::LONG_OFS_W-1){instr[10]}}, instr[10:0], 1'b0};
    bit_mask = 8'h01 << instr[rbx_pkg::BIT_MSB:rbx_pkg::BIT_LSB];
    if (opcode[rbx_pkg::ACCESS_FLAG]) begin
      bank = bank_select_value;
    end else if (opcode[7:0] < rbx_pkg::ACCESS_SPLIT) begin
      bank = rbx_pkg::ACCESS_LO_BANK;
    end else begin
      bank = rbx_pkg::ACCESS_HI_BANK;
    end
  end

  // ********************
  // Phase activity
  // ********************
  always_comb begin
    next_state = state;
    next_instr = instr;
    next_valid = valid;
    next_pc_base = pc_base;
    next_pc_value = pc_value;
    next_taken = taken;
    next_pc_load = 1'b0;
    next_file_rd = 1'b0;
    next_file_wr = 1'b0;
    next_file_addr = file_addr;
    next_file_wdata = file_wdata;
    next_nop_cycle = nop_cycle;
    next_decoded = decoded;
    next_phase_out = ph + 2'h1;
    case (ph)
      rbx_pkg::PH_Q1: begin
        if (state == rbx_pkg::ST_EXEC) begin
          next_instr = opcode;
          next_valid = 1'b1;
          next_decoded = in_ours;
          next_pc_base = pc_inc;
          if (in_set) begin
            next_file_rd = 1'b1;
            next_file_addr = {bank, opcode[7:0]};
          end
        end else begin
          next_valid = 1'b0;
          next_decoded = 1'b0;
        end
      end
      rbx_pkg::PH_Q2: begin
        next_taken = valid && ((is_cond && cond_true) || is_long);
        next_pc_value = pc_base + (is_long ? long_ofs : short_ofs);
        if (valid && is_set) begin
          next_file_wdata = file_rdata | bit_mask;
        end
      end
      rbx_pkg::PH_Q3: begin
        next_pc_load = taken;
        next_file_wr = valid && is_set;
      end
      rbx_pkg::PH_Q4: begin
        if (state == rbx_pkg::ST_EXEC && taken) begin
          next_state = rbx_pkg::ST_FLUSH;
          next_nop_cycle = 1'b1;
        end else begin
          next_state = rbx_pkg::ST_EXEC;
          next_nop_cycle = 1'b0;
        end
        next_taken = 1'b0;
      end
      default: begin
        next_state = rbx_pkg::ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= rbx_pkg::ST_EXEC;
      instr <= rbx_pkg::OPCODE_RESET;
      valid <= 1'b0;
      pc_base <= '0;
      pc_value <= '0;
      taken <= 1'b0;
      pc_load <= 1'b0;
      file_rd <= 1'b0;
      file_wr <= 1'b0;
      file_addr <= 12'h000;
      file_wdata <= 8'h00;
      nop_cycle <= 1'b0;
      decoded <= 1'b0;
      phase <= rbx_pkg::PH_Q2;
    end else begin
      state <= next_state;
      instr <= next_instr;
      valid <= next_valid;
      pc_base <= next_pc_base;
      pc_value <= next_pc_value;
      taken <= next_taken;
      pc_load <= next_pc_load;
      file_rd <= next_file_rd;
      file_wr <= next_file_wr;
      file_addr <= next_file_addr;
      file_wdata <= next_file_wdata;
      nop_cycle <= next_nop_cycle;
      decoded <= next_decoded;
      phase <= next_phase_out;
    end
  end

  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_carry_clear_jump: assert property ((ph == rbx_pkg::PH_Q2 && valid && instr[15:8] == rbx_pkg::OP_CARRY_CLEAR
    && !status_carry) |=> ##1 pc_load) else $error("carry clear jump not taken");
  a_not_neg_jump: assert property ((ph == rbx_pkg::PH_Q2 && valid && instr[15:8] == rbx_pkg::OP_NOT_NEGATIVE)
    |=> ##1 (pc_load == !$past(status_negative, 2))) else $error("not negative jump wrong");
  a_no_ovf_jump: assert property ((ph == rbx_pkg::PH_Q2 && valid && instr[15:8] == rbx_pkg::OP_NO_OVERFLOW)
    |=> ##1 (pc_load == !$past(status_overflow, 2))) else $error("no overflow jump wrong");
  a_nonzero_jump: assert property ((ph == rbx_pkg::PH_Q2 && valid && instr[15:8] == rbx_pkg::OP_NONZERO)
    |=> ##1 (pc_load == !$past(status_zero, 2))) else $error("nonzero jump wrong");
  a_neg_jump: assert property ((ph == rbx_pkg::PH_Q2 && valid && instr[15:8] == rbx_pkg::OP_NEGATIVE)
    |=> ##1 (pc_load == $past(status_negative, 2))) else $error("negative jump wrong");
  a_short_target: assert property ((ph == rbx_pkg::PH_Q2 && valid && is_cond)
    |=> pc_value == $past(pc_inc, 2) + short_ofs) else $error("short target wrong");
  a_long_jump: assert property ((ph == rbx_pkg::PH_Q2 && valid && is_long)
    |=> pc_value == $past(pc_inc, 2) + long_ofs ##1 pc_load ##1 nop_cycle [*4]) else $error("long jump wrong");
  a_taken_idle: assert property (pc_load |=> nop_cycle [*4] ##1 !nop_cycle) else $error("idle cycle wrong");
  a_untaken_single: assert property ((ph == rbx_pkg::PH_Q3 && !taken) |=> !pc_load ##1 !nop_cycle)
    else $error("untaken jump not single cycle");
  a_load_in_q4: assert property (pc_load |-> phase == rbx_pkg::PH_Q4) else $error("load outside Q4");
  a_set_sequence: assert property (file_rd |-> phase == rbx_pkg::PH_Q2 ##2 (file_wr && file_wdata ==
    ($past(file_rdata, 2) | bit_mask))) else $error("bit set sequence wrong");
  a_access_bank: assert property ((file_rd && !instr[rbx_pkg::ACCESS_FLAG]) |-> file_addr[11:8] ==
    (instr[7] ? rbx_pkg::ACCESS_HI_BANK : rbx_pkg::ACCESS_LO_BANK)) else $error("access bank wrong");
  a_bank_select: assert property ((file_rd && instr[rbx_pkg::ACCESS_FLAG]) |-> file_addr[11:8] ==
    $past(bank_select_value)) else $error("bank select not used");
  a_wr_in_q4: assert property (file_wr |-> phase == rbx_pkg::PH_Q4 && !pc_load) else $error("write out of Q4");

  c_taken_short: cover property (pc_load && !is_long);
  c_taken_long: cover property (pc_load && is_long);
  c_untaken: cover property (ph == rbx_pkg::PH_Q3 && valid && is_cond && !taken);
  c_bit_set: cover property (file_wr);

endmodule : rbx_exec

// *** test/rbx_exec_tb.sv ***
// Self-checking bench for the relative jump and file bit set executer.
// Assumes rbx_exec samples opcode at the Q1 edge and the bench plays the core around it.
`timescale 1ns/1ps
module rbx_exec_tb;
  // ********************
  // Signals
  // ********************
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] opcode = 16'h0000;
  logic [20:0] pc_inc = 21'h0_0000;
  logic [3:0] flg = 4'h0;
  logic [3:0] bsv = 4'h0;
  logic [7:0] rdata = 8'h00;
  logic [1:0] phase;
  logic nop_cycle;
  logic decoded;
  logic pc_load;
  logic file_rd;
  logic file_wr;
  logic [20:0] pc_value;
  logic [11:0] file_addr;
  logic [7:0] file_wdata;
  integer n_fail = 0;
  integer tests_run = 0;
  integer seed = 7;

  always #5 clk = ~clk;

  rbx_exec uut (.clk(clk), .reset(reset), .opcode(opcode), .pc_inc(pc_inc), .status_carry(flg[0]),
    .status_zero(flg[1]), .status_overflow(flg[2]), .status_negative(flg[3]), .bank_select_value(bsv),
    .file_rdata(rdata), .phase(phase), .nop_cycle(nop_cycle), .decoded(decoded), .pc_load(pc_load),
    .pc_value(pc_value), .file_rd(file_rd), .file_wr(file_wr), .file_addr(file_addr),
    .file_wdata(file_wdata));

  // ********************
  // Helpers
  // ********************
  task automatic chk_val(input string nm, input logic [20:0] e, input logic [20:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val

  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  // ********************
  // One instruction with its model
  // ********************
  task automatic run(input logic [15:0] op, input logic [3:0] f);
    int w;
    int off;
    logic tk;
    logic br;
    logic bs;
    logic ours;
    logic [20:0] tgt;
    logic [11:0] adr;
    w = 0;
    while (!(phase === 2'h0 && nop_cycle === 1'b0) && w < 20) begin
      tick();
      w++;
    end
    if (w >= 20) n_fail++;
    opcode = op;
    pc_inc = 21'($random(seed));
    bsv = 4'($random(seed));
    rdata = 8'($random(seed));
    flg = f;
    br = (op[15:11] == rbx_pkg::OP_REL_JUMP);
    bs = (op[15:12] == rbx_pkg::OP_SET_BIT);
    ours = (op[15:12] == 4'hE) || br || bs;
    case (op[15:8])
      rbx_pkg::OP_CARRY_CLEAR: tk = !f[0];
      rbx_pkg::OP_NOT_NEGATIVE: tk = !f[3];
      rbx_pkg::OP_NO_OVERFLOW: tk = !f[2];
      rbx_pkg::OP_NONZERO: tk = !f[1];
      rbx_pkg::OP_NEGATIVE: tk = f[3];
      default: tk = br;
    endcase
    if (br) off = $signed(op[10:0]);
    else off = $signed(op[7:0]);
    tgt = 21'(int'(pc_inc) + 2 * off);
    adr = {op[8] ? bsv : (op[7:0] < rbx_pkg::ACCESS_SPLIT ? rbx_pkg::ACCESS_LO_BANK : rbx_pkg::ACCESS_HI_BANK),
      op[7:0]};
    tick();
    chk_val("phase", {19'h0, rbx_pkg::PH_Q2}, {19'h0, phase});
    chk_bit("decoded", ours, decoded);
    chk_bit("file_rd", bs, file_rd);
    if (bs) chk_val("file_addr", adr, file_addr);
    tick();
    if (tk) chk_val("pc_value", tgt, pc_value);
    if (bs) chk_val("file_wdata", rdata | (8'h01 << op[11:9]), file_wdata);
    tick();
    chk_bit("pc_load", tk, pc_load);
    chk_bit("file_wr", bs, file_wr);
    tick();
    chk_bit("nop_cycle", tk, nop_cycle);
    if (tk) begin
      opcode = 16'h8000;
      tick();
      chk_bit("flushed file_rd", 1'b0, file_rd);
      chk_bit("pc_load idle", 1'b0, pc_load);
    end
  endtask : run

  // ********************
  // Main sequence
  // ********************
  initial begin
    int k;
    int j;
    logic [15:0] op;
    logic [3:0] f;
    logic [7:0] hi [5];
    hi = '{rbx_pkg::OP_CARRY_CLEAR, rbx_pkg::OP_NOT_NEGATIVE, rbx_pkg::OP_NO_OVERFLOW,
      rbx_pkg::OP_NONZERO, rbx_pkg::OP_NEGATIVE};
    repeat (3) @(posedge clk);
    #1;
    reset = 1'b0;
    for (k = 0; k < 8; k++) begin
      for (j = 0; j < 6; j++) begin
        op = 16'($random(seed));
        f = 4'($random(seed));
        if (j < 2) f = (k == 4) ? 4'h8 : 4'h0;
        if (k < 5) op = {hi[k], j == 0 ? 8'h80 : j == 1 ? 8'h7F : op[7:0]};
        else if (k == 5) op = {rbx_pkg::OP_REL_JUMP, j == 0 ? 11'h400 : j == 1 ? 11'h3FF : op[10:0]};
        else if (k == 6) op = {rbx_pkg::OP_SET_BIT, op[11:0]};
        else op = {4'h0, op[11:0]};
        run(op, f);
      end
    end
    reset = 1'b1;
    tick();
    chk_val("reset phase", 21'h1, {19'h0, phase});
    chk_bit("reset pc_load", 1'b0, pc_load);
    tick();
    reset = 1'b0;
    run(16'h8F85, 4'h0);
    conclude();
  end

  // ********************
  // Watchdog
  // ********************
  initial begin
    #50000;
    n_fail++;
    conclude();
  end
endmodule : rbx_exec_tb
